// ---- core/sep_core.sv ----
// Purpose: Command, protection and array logic of a serial bus EEPROM slave.
// Assumes: Bus mode 0; pins oversampled by ref_clk_i at least 8 times per bit.
// Notes:   The internal write cycle length is WC_CYC core cycles.
//
// Functional notes
// RL1: Status bit 0 shows busy: one while an internal write runs.
// RL2: Status bit 1 shows the write latch.
// RL3: Bits 6..4 read zero when idle; all eight bits read one when busy.
// RL4: Protect and arm bits change only via latch set plus a timed write.
// RL5: Small array: codes 00..11 protect none, top quarter, top half, all.
// RL6: Large array: same quarter, half, all split; protected bytes are read-only.
// RL7: Pin protection is active only with pin low and arm bit set.
// RL8: Active pin protection rejects all status writes and protected array writes.
// RL9: Arm bit cannot be cleared while pin protection holds.
// RL10: Array writes need latch set and an unprotected address.
// RL11: Read takes opcode and 16-bit address, then shifts data out.
// RL12: Continued reads increment the address and wrap to zero.
// RL13: The master sets the latch in its own earlier selection.
// RL14: Addresses inside the protected block are never programmed.
// RL15: While busy, only status read is obeyed.
// RL16: Programming starts only on the select rise after a whole byte.
// RL17: Page writes step only the low five address bits.
// RL18: Each completed write cycle clears the write latch.
// RL19: Write opcodes with latch clear are ignored until a new selection.
// RL20: Opcodes latch set 06, latch clear 04, status read 05.
// RL21: Opcodes status write 01, array read 03, array write 02.
// RL22: Status bit 7 arm, bit 3 protect high, bit 2 protect low.
// RL23: Everything moves MSB first; each operation starts on select fall.
// RL24: Input sampled on clock rise, output changed after clock fall.
`timescale 1ns/1ps
module sep_core
	import sep_pkg::*;
#(
	parameter int unsigned AW     = ARR_AW,
	parameter int unsigned WC_CYC = WC_CYCLES
) (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic cs_n_i,
	input  wire logic sck_i,
	input  wire logic si_i,
	input  wire logic wp_n_i,
	output logic      so_o,
	output logic      so_oe_o
);
	localparam int unsigned CW = $clog2(WC_CYC + 1);

	// =====================================================================
	// Pin synchronisers and edge detection
	logic [3:0] pins_s;
	logic       cs_n_s, sck_s, si_s, wp_n_s;
	logic       sck_pq, sck_pd, cs_pq, cs_pd;
	logic       rise, fall, cs_fall, cs_rise;

	sep_sync #(.W(4), .RST(SYNC_RST)) u_sync (
		.clk_i  (ref_clk_i),
		.nrst_i (nrst_i),
		.d_i    ({cs_n_i, sck_i, si_i, wp_n_i}),
		.q_o    (pins_s)
	);
	assign {cs_n_s, sck_s, si_s, wp_n_s} = pins_s;

	// Sampling on rise and shifting after fall gives mode 0 timing.
	assign rise    = sck_s && !sck_pq && !cs_n_s; // RL24
	assign fall    = !sck_s && sck_pq && !cs_n_s; // RL24
	assign cs_fall = !cs_n_s && cs_pq; // RL23
	assign cs_rise = cs_n_s && !cs_pq;

	// =====================================================================
	// State
	sep_state_e       st_q, st_d;
	logic [2:0]       bit_q, bit_d;
	logic [7:0]       rx_q, rx_d, tx_q, tx_d, srn_q, srn_d;
	logic [15:0]      adr_q, adr_d;
	logic             ab_q, ab_d, rd_q, rd_d, any_q, any_d;
	logic             so_q, so_d, oe_q, oe_d;
	logic             latch_q, latch_d, arm_q, arm_d, busy_q, busy_d, kind_q, kind_d;
	logic [1:0]       bp_q, bp_d;
	logic [CW-1:0]    wcnt_q, wcnt_d;
	logic [5:0]       cidx_q, cidx_d;
	logic [PAGE_N-1:0] vld_q, vld_d;
	logic             pre_q, pre_d;
	logic [AW-1:0]    pa_q, pa_d;

	// Datapath strobes and storage.
	logic [7:0]       rxb, stat, obyte;
	logic             byte_done, hwp, pb_we, mem_we, pop;
	logic [AW-1:0]    mem_wa;
	logic [7:0]       pbuf_q [PAGE_N];
	logic [7:0]       mem_q [2**AW];
	logic             f_rdy, f_vld;
	logic [7:0]       f_dat;

	// =====================================================================
	// Block protection decode; boundaries fall on page edges.
	function automatic logic prot(input logic [AW-1:0] a, input logic [1:0] bp);
		case (bp)
			2'h1:    prot = (a[AW-1:AW-2] == 2'h3); // RL5 RL6
			2'h2:    prot = a[AW-1]; // RL5 RL6
			2'h3:    prot = 1'b1; // RL5 RL6
			default: prot = 1'b0;
		endcase
	endfunction

	// Status image; a busy device answers all ones.
	always_comb begin
		stat             = '0;
		stat[ST_LATCH_B] = latch_q; // RL2
		stat[ST_BPLO_B]  = bp_q[0]; // RL22
		stat[ST_BPHI_B]  = bp_q[1]; // RL22
		stat[ST_ARM_B]   = arm_q; // RL22
		if (busy_q) begin
			stat = ST_BUSY_VAL; // RL1 RL3
		end
	end

	assign hwp       = !wp_n_s && arm_q; // RL7
	assign rxb       = {rx_q[6:0], si_s};
	assign byte_done = rise && (bit_q == 3'h7);
	assign obyte     = (st_q == SEP_RD) ? (f_vld ? f_dat : 8'h00) : stat;

	// =====================================================================
	// Read prefetch buffer: bytes run ahead of the shifter and stall when full.
	sep_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.clk_i       (ref_clk_i),
		.nrst_i      (nrst_i),
		.clr_i       (cs_fall || cs_rise),
		.in_valid_i  (pre_q),
		.in_data_i   (mem_q[pa_q]),
		.in_ready_o  (f_rdy),
		.out_valid_o (f_vld),
		.out_data_o  (f_dat),
		.out_ready_i (pop)
	);

	// =====================================================================
	// Sequencer next state: framing, decode, shifting and write cycle.
	always_comb begin
		st_d = st_q; bit_d = bit_q; rx_d = rx_q; tx_d = tx_q; srn_d = srn_q;
		adr_d = adr_q; ab_d = ab_q; rd_d = rd_q; any_d = any_q; so_d = so_q;
		oe_d = oe_q; latch_d = latch_q; arm_d = arm_q; busy_d = busy_q;
		kind_d = kind_q; bp_d = bp_q; wcnt_d = wcnt_q; cidx_d = cidx_q;
		vld_d = vld_q; pre_d = pre_q; pa_d = pa_q;
		sck_pd = sck_s;
		cs_pd  = cs_n_s;
		pb_we = 1'b0; mem_we = 1'b0; pop = 1'b0;
		mem_wa = {adr_q[AW-1:PAGE_AW], cidx_q[PAGE_AW-1:0]};

		// Serial input shifts MSB first on every sampled rise.
		if (rise) begin
			bit_d = bit_q + 3'h1;
			rx_d  = rxb; // RL23
		end

		case (st_q)
			SEP_CMD: begin
				if (byte_done) begin
					st_d = SEP_IGN;
					if (rxb[7:4] != OPC_HI) begin
						st_d = SEP_IGN;
					end else if (busy_q && rxb[2:0] != OPC_SRD) begin
						st_d = SEP_IGN; // RL15
					end else begin
						case (rxb[2:0])
							OPC_LSET: st_d = SEP_LSET; // RL20
							OPC_LCLR: st_d = SEP_LCLR; // RL20
							OPC_SRD:  st_d = SEP_SR; // RL20
							OPC_SWR:  st_d = latch_q ? SEP_SWR : SEP_IGN; // RL21 RL4 RL19
							OPC_ARD: begin
								st_d = SEP_ADR; // RL21 RL11
								rd_d = 1'b1;
							end
							OPC_AWR: begin
								st_d = latch_q ? SEP_ADR : SEP_IGN; // RL21 RL10 RL19
								rd_d = 1'b0;
							end
							default:  st_d = SEP_IGN;
						endcase
					end
				end
			end
			SEP_ADR: begin
				if (byte_done) begin
					adr_d = {adr_q[7:0], rxb};
					ab_d  = !ab_q;
					if (ab_q) begin
						st_d = rd_q ? SEP_RD : SEP_WR;
						pre_d = rd_q; // RL11
						pa_d  = {adr_q[AW-9:0], rxb}; // RL11
					end
				end
			end
			SEP_WR: begin
				if (byte_done) begin
					pb_we = 1'b1;
					vld_d[adr_q[PAGE_AW-1:0]] = 1'b1;
					adr_d[PAGE_AW-1:0] = adr_q[PAGE_AW-1:0] + 5'h1; // RL17
					any_d = 1'b1;
				end
			end
			SEP_SWR: begin
				if (byte_done) begin
					srn_d = rxb;
					any_d = 1'b1;
				end
			end
			default: begin
			end
		endcase

		// Output shifter: a new byte is loaded on the fall that opens it.
		if (fall && (st_q == SEP_RD || st_q == SEP_SR)) begin
			oe_d = 1'b1; // RL24
			if (bit_q == 3'h0) begin
				pop  = (st_q == SEP_RD);
				so_d = obyte[7]; // RL11
				tx_d = {obyte[6:0], 1'b0};
			end else begin
				so_d = tx_q[7];
				tx_d = {tx_q[6:0], 1'b0};
			end
		end

		// Prefetch walks the whole array and wraps past the top.
		if (pre_q && f_rdy) begin
			pa_d = pa_q + AW'(1); // RL12
		end

		// Internal write cycle: commit the page, then time out.
		if (busy_q) begin
			wcnt_d = wcnt_q + CW'(1);
			if (cidx_q < 6'(PAGE_N)) begin
				cidx_d = cidx_q + 6'h1;
				if (kind_q && cidx_q == 6'h0) begin
					bp_d  = {srn_q[ST_BPHI_B], srn_q[ST_BPLO_B]}; // RL4
					arm_d = srn_q[ST_ARM_B]; // RL4
				end
				mem_we = !kind_q && vld_q[cidx_q[PAGE_AW-1:0]] && !prot(mem_wa, bp_q); // RL14
			end
			if (wcnt_q == CW'(WC_CYC - 1)) begin
				busy_d  = 1'b0;
				latch_d = 1'b0; // RL18
				vld_d   = '0;
			end
		end

		// Select rise closes the frame and may launch programming.
		if (cs_rise) begin
			st_d = SEP_IDLE;
			oe_d = 1'b0;
			pre_d = 1'b0;
			if (bit_q == 3'h0) begin
				if (st_q == SEP_LSET) begin
					latch_d = 1'b1;
				end
				if (st_q == SEP_LCLR) begin
					latch_d = 1'b0;
				end
				if (st_q == SEP_WR && any_q && !prot(adr_q[AW-1:0], bp_q)) begin
					busy_d = 1'b1; // RL16 RL10
					kind_d = 1'b0;
					wcnt_d = '0;
					cidx_d = '0;
				end
				if (st_q == SEP_SWR && any_q && !hwp) begin
					busy_d = 1'b1; // RL16 RL8 RL9
					kind_d = 1'b1;
					wcnt_d = '0;
					cidx_d = '0;
				end
			end
		end

		// Select fall (to command) or rise (to idle) is the only way to leave the ignore state.
		if (cs_fall) begin
			st_d  = SEP_CMD; // RL19 RL23
			bit_d = 3'h0;
			ab_d  = 1'b0;
			any_d = 1'b0;
			if (!busy_q) begin
				vld_d = '0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= SEP_IDLE; bit_q <= '0; rx_q <= '0; tx_q <= '0; srn_q <= '0;
			adr_q <= '0; ab_q <= 1'b0; rd_q <= 1'b0; any_q <= 1'b0; so_q <= 1'b0;
			oe_q <= 1'b0; latch_q <= LATCH_RST; arm_q <= ARM_RST; busy_q <= 1'b0;
			kind_q <= 1'b0; bp_q <= BP_RST; wcnt_q <= '0; cidx_q <= '0;
			vld_q <= '0; pre_q <= 1'b0; pa_q <= '0; sck_pq <= 1'b0; cs_pq <= 1'b1;
		end else begin
			st_q <= st_d; bit_q <= bit_d; rx_q <= rx_d; tx_q <= tx_d; srn_q <= srn_d;
			adr_q <= adr_d; ab_q <= ab_d; rd_q <= rd_d; any_q <= any_d; so_q <= so_d;
			oe_q <= oe_d; latch_q <= latch_d; arm_q <= arm_d; busy_q <= busy_d;
			kind_q <= kind_d; bp_q <= bp_d; wcnt_q <= wcnt_d; cidx_q <= cidx_d;
			vld_q <= vld_d; pre_q <= pre_d; pa_q <= pa_d; sck_pq <= sck_pd; cs_pq <= cs_pd;
		end
	end

	// =====================================================================
	// Page buffer and array storage; no reset, contents are data.
	always_ff @(posedge ref_clk_i) begin
		if (pb_we) begin
			pbuf_q[adr_q[PAGE_AW-1:0]] <= rxb;
		end
		if (mem_we) begin
			mem_q[mem_wa] <= pbuf_q[cidx_q[PAGE_AW-1:0]];
		end
	end

	assign so_o    = so_q;
	assign so_oe_o = oe_q;

	// =====================================================================
	// Assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_wc_end;
		busy_q && wcnt_q == CW'(WC_CYC - 1);
	endsequence

	sequence s_start;
		cs_rise && (st_q == SEP_WR || st_q == SEP_SWR) && bit_q == 3'h0;
	endsequence

	idle_status_bits_a: assert property (!busy_q |-> stat[6:4] == 3'h0 && !stat[0]) // RL3
		else $error("Idle status shows busy or upper bits");
	busy_reads_ones_a: assert property (busy_q |-> stat == 8'hFF) // RL1
		else $error("Busy status is not all ones");
	latch_auto_clear_a: assert property (s_wc_end |=> !latch_q && !busy_q) // RL18
		else $error("Write cycle end left latch or busy set");
	busy_cmd_ign_a: assert property (st_q == SEP_CMD && byte_done && busy_q && // RL15
		rxb[2:0] != OPC_SRD |=> st_q == SEP_IGN)
		else $error("Command obeyed while busy");
	no_latch_wr_a: assert property (st_q == SEP_CMD && byte_done && !latch_q && // RL19
		rxb[2:0] == OPC_AWR |=> st_q == SEP_IGN ##1 st_q != SEP_WR)
		else $error("Write accepted with latch clear");
	prot_no_prog_a: assert property (mem_we |-> !prot(mem_wa, bp_q)) // RL14
		else $error("Protected address programmed");
	page_step_a: assert property (st_q == SEP_WR && byte_done && !cs_fall |=> // RL17
		adr_q[4:0] == $past(adr_q[4:0]) + 5'h1 && adr_q[15:5] == $past(adr_q[15:5]))
		else $error("Page address step wrong");
	read_incr_a: assert property (pre_q && f_rdy && !cs_rise |=> pa_q == $past(pa_q) + AW'(1)) // RL12
		else $error("Read address did not advance");
	start_on_rise_a: assert property ($rose(busy_q) |-> $past(cs_rise)) // RL16
		else $error("Programming started without select rise");
	hw_prot_sr_a: assert property (s_start ##0 (st_q == SEP_SWR && hwp) |=> !busy_q) // RL8
		else $error("Status write ran under pin protection");
	arm_kept_a: assert property (arm_q && !wp_n_s && !busy_q |=> arm_q) // RL9
		else $error("Arm bit cleared under pin protection");
endmodule // sep_core

// ---- inc/sep_pkg.sv ----
// Purpose: Shared constants and types of the serial EEPROM command and protection core.
// Assumes: A 100 MHz core clock that oversamples the serial bus pins.
// Notes:   The array size is a module parameter; ARR_AW is its default.
package sep_pkg;

	// =====================================================================
	// Timing
	localparam int unsigned CLK_MHZ   = 100;
	localparam int unsigned T_WC_MS   = 5;
	localparam int unsigned WC_CYCLES = T_WC_MS * 1000 * CLK_MHZ;

	// =====================================================================
	// Geometry
	localparam int unsigned ARR_AW  = 13;
	localparam int unsigned PAGE_AW = 5;
	localparam int unsigned PAGE_N  = 32;
	localparam int unsigned FIFO_W  = 8;
	localparam int unsigned FIFO_D  = 16;

	// =====================================================================
	// Instruction codes: upper nibble zero, bit 3 ignored, low three bits decoded.
	localparam logic [3:0] OPC_HI   = 4'h0;
	localparam logic [2:0] OPC_LSET = 3'h6;
	localparam logic [2:0] OPC_LCLR = 3'h4;
	localparam logic [2:0] OPC_SRD  = 3'h5;
	localparam logic [2:0] OPC_SWR  = 3'h1;
	localparam logic [2:0] OPC_ARD  = 3'h3;
	localparam logic [2:0] OPC_AWR  = 3'h2;

	// =====================================================================
	// Status register layout and reset values.
	localparam int unsigned ST_BUSY_B  = 0;
	localparam int unsigned ST_LATCH_B = 1;
	localparam int unsigned ST_BPLO_B  = 2;
	localparam int unsigned ST_BPHI_B  = 3;
	localparam int unsigned ST_ARM_B   = 7;
	localparam logic [7:0]  ST_BUSY_VAL = 8'hFF;
	localparam logic [1:0]  BP_RST      = 2'h0;
	localparam logic        ARM_RST     = 1'h0;
	localparam logic        LATCH_RST   = 1'h0;
	localparam logic [3:0]  SYNC_RST    = 4'h9;

	// =====================================================================
	// Frame sequencer states.
	typedef enum logic [3:0] {
		SEP_IDLE, SEP_CMD, SEP_ADR, SEP_WR, SEP_SWR,
		SEP_RD, SEP_SR, SEP_LSET, SEP_LCLR, SEP_IGN
	} sep_state_e;

endpackage

// ---- core/sep_sync.sv ----
// Purpose: Two-flop synchroniser for the serial bus pins.
// Assumes: Inputs are asynchronous to clk_i.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
module sep_sync #(
	parameter int unsigned W   = 4,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	// =====================================================================
	// Both stages reset to the idle pin levels so no false edge appears.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_q <= RST;
			q_o    <= RST;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule // sep_sync

// ---- core/sep_fifo.sv ----
// Purpose: Small FIFO that buffers prefetched read bytes.
// Assumes: D is a power of two.
// Notes:   Synchronous clear empties it at every frame boundary.
`timescale 1ns/1ps
module sep_fifo #(
	parameter int unsigned W = 8,
	parameter int unsigned D = 16
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         clr_i,
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	output logic              out_valid_o,
	output logic      [W-1:0] out_data_o,
	input  wire logic         out_ready_i
);
	localparam int unsigned PW = $clog2(D);
	logic [W-1:0]  buf_q [D];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [PW:0]   cnt_q, cnt_d;
	logic          push, pop;

	assign in_ready_o  = (cnt_q != (PW+1)'(D));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = buf_q[rp_q];

	// =====================================================================
	// Pointer and count update; pointers wrap naturally at D.
	always_comb begin
		push  = in_valid_i && in_ready_o;
		pop   = out_ready_i && out_valid_o;
		wp_d  = wp_q + PW'(push);
		rp_d  = rp_q + PW'(pop);
		cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		if (clr_i) begin
			wp_d  = '0;
			rp_d  = '0;
			cnt_d = '0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset; contents are meaningless while empty.
	always_ff @(posedge clk_i) begin
		if (push && !clr_i) begin
			buf_q[wp_q] <= in_data_i;
		end
	end
endmodule // sep_fifo

// ---- tb/sep_master.sv ----
// Purpose: Behavioural bus master in mode 0 that drives the serial EEPROM core.
// Assumes: ref_clk_i is the core clock; one serial bit takes 16 core clocks (160 ns).
// Notes:   Read bits taken while the output is not enabled come back as unknown.
`timescale 1ns/1ps
module sep_master (
	input  wire logic ref_clk_i,
	input  wire logic so_i,
	input  wire logic so_oe_i,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o
);
	localparam int HALF = 8;

	// =====================================================================
	// Idle levels: select high, clock parked low between frames.
	initial begin
		cs_n_o = 1'b1;
		sck_o  = 1'b0;
		si_o   = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// =====================================================================
	// One whole frame: send tx, then clock in nrx bytes.
	task automatic frame(input logic [7:0] tx[$], input int nrx, output logic [7:0] rx[$]);
		logic [7:0] sh;
		int         nb;
		rx = {};
		nb = tx.size() + nrx;
		@(posedge ref_clk_i);
		cs_n_o <= 1'b0;
		idle(HALF);
		for (int i = 0; i < nb; i++) begin
			sh = (i < tx.size()) ? tx[i] : 8'h00;
			for (int b = 7; b >= 0; b--) begin
				si_o <= sh[b];
				idle(HALF);
				sck_o <= 1'b1;
				// Sample at the rise; a released line must not pass for data.
				sh[b] = (so_oe_i === 1'b1) ? so_i : 1'bx;
				idle(HALF);
				sck_o <= 1'b0;
			end
			if (i >= tx.size()) begin
				rx.push_back(sh);
			end
		end
		// Select rises inside the low time right after the last bit.
		idle(HALF / 2);
		cs_n_o <= 1'b1;
		si_o   <= ~si_o;
		idle(HALF);
	endtask
endmodule // sep_master

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the serial EEPROM command and protection core.
// Assumes: Large array variant (13 address bits) with a shortened write cycle.
// Notes:   All expectations come from the opcode map, status layout and protection levels.
`timescale 1ns/1ps
module testbench
	import sep_pkg::*;
;
	localparam int unsigned WC = 600;

	logic       ref_clk_i;
	logic       nrst_i;
	logic       wp_n_i;
	logic       cs_n;
	logic       sck;
	logic       si;
	logic       so;
	logic       so_oe;
	int         n_fail;
	int         samples_checked;
	logic [7:0] tx[$];
	logic [7:0] rx[$];

	// =====================================================================
	// Clock and instances.
	initial ref_clk_i = 1'b0;
	always #5 ref_clk_i = ~ref_clk_i;

	sep_master m (
		.ref_clk_i (ref_clk_i),
		.so_i      (so),
		.so_oe_i   (so_oe),
		.cs_n_o    (cs_n),
		.sck_o     (sck),
		.si_o      (si)
	);

	sep_core #(.AW(13), .WC_CYC(WC)) dut (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.cs_n_i    (cs_n),
		.sck_i     (sck),
		.si_i      (si),
		.wp_n_i    (wp_n_i),
		.so_o      (so),
		.so_oe_o   (so_oe)
	);

	// =====================================================================
	// Checking and closing.
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// =====================================================================
	// Access tasks built on whole frames.
	task automatic go(input int nrx);
		m.frame(tx, nrx, rx);
	endtask

	task automatic stat(input logic [7:0] exp);
		tx = {8'h05};
		go(1);
		chk8("status", exp, rx[0]);
	endtask

	task automatic latch(input logic [7:0] op);
		tx = {op};
		go(0);
	endtask

	task automatic hdr(input logic [7:0] op, input logic [15:0] a);
		tx = {op, a[15:8], a[7:0]};
	endtask

	task automatic wr1(input logic [15:0] a, input logic [7:0] d);
		hdr(8'h02, a);
		tx.push_back(d);
		go(0);
	endtask

	task automatic swr(input logic [7:0] v);
		tx = {8'h01, v};
		go(0);
	endtask

	task automatic rd(input logic [15:0] a, input int n);
		hdr(8'h03, a);
		go(n);
	endtask

	// Poll busy with a bound, so a stuck cycle cannot hang the run.
	task automatic wait_ready;
		int k;
		k = 0;
		tx = {8'h05};
		do begin
			go(1);
			k++;
		end while (rx[0][0] !== 1'b0 && k < 40);
		chk8("ready", 8'h00, {7'h00, rx[0][0]});
	endtask

	// Content of page zero after the 33-byte write starting at offset 0x10.
	function automatic logic [7:0] pg(input int a);
		return (a == 16) ? 8'h60 : 8'h40 + 8'((a + 16) % 32);
	endfunction

	// =====================================================================
	// Watchdog: the sequence needs about 300 us.
	initial begin
		#800_000;
		n_fail++;
		summarize;
	end

	// =====================================================================
	// Main sequence.
	initial begin
		nrst_i = 1'b0;
		wp_n_i = 1'b1;
		repeat (10) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		stat(8'h00);
		wr1(16'h0010, 8'h55);
		stat(8'h00);
		latch(8'h06);
		stat(8'h02);
		latch(8'h04);
		stat(8'h00);
		// A nonzero upper nibble is no opcode, so the latch must stay clear.
		latch(8'h16);
		stat(8'h00);
		latch(8'h0E);
		stat(8'h02);
		// Page write of 33 bytes: offsets wrap inside the page.
		hdr(8'h02, 16'h0010);
		for (int k = 0; k < 33; k++) begin
			tx.push_back(8'h40 + k[7:0]);
		end
		go(0);
		stat(8'hFF);
		rd(16'h0010, 1);
		chk8("busy read", 8'hxx, rx[0]);
		wait_ready;
		stat(8'h00);
		latch(8'h06);
		wr1(16'h1FFF, 8'hA5);
		wait_ready;
		// Upper unused address bits are ignored; the read wraps from the top.
		rd(16'hFFFF, 33);
		chk8("top byte", 8'hA5, rx[0]);
		for (int a = 0; a < 32; a++) begin
			chk8("page byte", pg(a), rx[a + 1]);
		end
		// Protect all; bits 6..4 never stick.
		latch(8'h06);
		swr(8'hFC);
		wait_ready;
		stat(8'h8C);
		latch(8'h06);
		wr1(16'h0005, 8'h11);
		stat(8'h8E);
		rd(16'h0005, 1);
		chk8("protected byte", pg(5), rx[0]);
		// Top quarter only; the latch is still set from the refused write.
		swr(8'h84);
		wait_ready;
		stat(8'h84);
		latch(8'h06);
		wr1(16'h1800, 8'h22);
		stat(8'h86);
		wr1(16'h17FF, 8'h33);
		wait_ready;
		rd(16'h17FF, 1);
		chk8("below quarter", 8'h33, rx[0]);
		// Pin protection armed and active.
		wp_n_i <= 1'b0;
		latch(8'h06);
		swr(8'h00);
		stat(8'h86);
		wr1(16'h0005, 8'h77);
		wait_ready;
		rd(16'h0005, 1);
		chk8("pin low free byte", 8'h77, rx[0]);
		stat(8'h84);
		// Pin high releases the status register.
		wp_n_i <= 1'b1;
		latch(8'h06);
		swr(8'h00);
		wait_ready;
		stat(8'h00);
		summarize;
	end
endmodule // testbench
